// ===== pkg/isie_consts.svh
`ifndef ISIE_CONSTS_SVH
`define ISIE_CONSTS_SVH

// ************************************************************
// opcode fields
// ************************************************************
`define ISIE_OP_MOVS        8'hEB
`define ISIE_OP_PUSH        8'hFA
`define ISIE_OP_SUB         8'hE9
`define ISIE_OP_CALL_VIA_WORKING_REGISTER       16'h0014
`define ISIE_W2_PREFIX      4'hF
`define ISIE_MOVS_KIND_BIT  7
`define ISIE_SUB_RET_SEL    2'h3
`define ISIE_PC_STEP        21'h000002

// ************************************************************
// addressing
// ************************************************************
`define ISIE_OFFSET_MAX     8'h5F
`define ISIE_ACCESS_SPLIT   8'h80
`define ISIE_ACCESS_HI_BASE 4'hF
`define ISIE_IND_SPAN       12'h005
`define ISIE_IND0_BASE      12'hFEB
`define ISIE_IND1_BASE      12'hFE3
`define ISIE_IND2_BASE      12'hFDB

// ************************************************************
// reset values
// ************************************************************
`define ISIE_FSR_RESET      12'h000
`define ISIE_ZERO_DATA      8'h00

`endif

// ===== pkg/isie_pkg.sv
package isie_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MOV2,
        ST_NOP2
    } isie_state_t;

    typedef logic [11:0] isie_addr_t;
    typedef logic [20:0] isie_pc_t;

endpackage

// ===== src/isie_core.sv
// What this block does
// [RL1] call via working register pushes and jumps
// [RL2] indexed-to-file source is pointer plus offset
// [RL3] indexed-to-file decoded as two prefixed words
// [RL4] indexed-to-indexed decoded as two prefixed words
// [RL5] both indexed addresses are pointer plus offsets
// [RL6] moves reach the whole 4096-byte space
// [RL7] program never targets counter or stack bytes
// [RL8] indirect source address reads back zero
// [RL9] indirect indexed destination makes a no-operation
// [RL10] moves: two words, read then write
// [RL11] push literal writes then decrements pointer
// [RL12] push literal recognised by upper opcode byte
// [RL13] subtract six-bit literal from selected pointer
// [RL14] select three subtracts then returns, two cycles
// [RL15] extension also enables indexed offset addressing
// [RL16] extension off: access bit picks bank
// [RL17] low access operands become stack pointer offsets
// [RL18] operands above threshold keep access meaning
// [RL19] zero stack pointer reproduces access addressing
// [RL20] destination select bit keeps its meaning
// [RL21] extension active only with enable bit set
`timescale 1ns/1ps
`include "isie_consts.svh"

module isie_core (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    // configuration
    input  wire logic              extension_enable_bit_i,
    // instruction stream
    input  wire logic              instr_valid_i,
    input  wire logic [15:0]       instr_i,
    // core state
    input  wire logic [7:0]        working_register_i,
    input  wire isie_pkg::isie_pc_t pc_i,
    input  wire logic [7:0]        program_counter_high_latch_i,
    input  wire logic [4:0]        program_counter_upper_latch_i,
    input  wire isie_pkg::isie_pc_t return_stack_top_i,
    input  wire logic [3:0]        bank_select_register_i,
    // standard byte/bit operand
    input  wire logic              std_valid_i,
    input  wire logic [7:0]        std_file_i,
    input  wire logic              std_access_i,
    input  wire logic              std_dest_i,
    // data memory
    input  wire logic [7:0]        rd_data_i,
    output logic                   rd_en_o,
    output isie_pkg::isie_addr_t   rd_addr_o,
    output logic                   wr_en_o,
    output isie_pkg::isie_addr_t   wr_addr_o,
    output logic [7:0]             wr_data_o,
    // pointers
    output isie_pkg::isie_addr_t   indirect_pointer0_o,
    output isie_pkg::isie_addr_t   indirect_pointer1_o,
    output isie_pkg::isie_addr_t   stack_pointer_register_o,
    // program flow
    output logic                   pc_load_o,
    output isie_pkg::isie_pc_t     pc_target_o,
    output logic                   ret_push_o,
    output isie_pkg::isie_pc_t     ret_push_data_o,
    output logic                   ret_pop_o,
    output logic                   busy_o,
    // standard operand result
    output logic                   std_addr_valid_o,
    output isie_pkg::isie_addr_t   std_addr_o,
    output logic                   std_dest_to_work_o
);
    import isie_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    isie_state_t state, next_state;
    isie_addr_t  indirect_pointer [3];
    isie_addr_t  next_fsr [3];
    logic        mov_indexed, next_mov_indexed;
    logic        src_indirect, next_src_indirect;
    logic        next_rd_en, next_wr_en, next_pc_load, next_ret_push, next_ret_pop;
    isie_addr_t  next_rd_addr, next_wr_addr, next_std_addr;
    logic [7:0]  next_wr_data;
    isie_pc_t    next_pc_target, next_ret_push_data;
    logic        next_std_valid, next_std_dest;
    logic        next_busy;

    // indirect register windows sit at the top of the data space
    function automatic logic is_indirect(input isie_addr_t a);
        is_indirect = (a >= `ISIE_IND0_BASE && a < `ISIE_IND0_BASE + `ISIE_IND_SPAN)
                   || (a >= `ISIE_IND1_BASE && a < `ISIE_IND1_BASE + `ISIE_IND_SPAN)
                   || (a >= `ISIE_IND2_BASE && a < `ISIE_IND2_BASE + `ISIE_IND_SPAN);
    endfunction

    // ************************************************************
    // decode
    // ************************************************************
    logic       ext_on;
    logic       dec_movs, dec_push, dec_sub, dec_call_via_working_register, w2_ok;
    isie_addr_t src_addr, dst_addr;
    logic [1:0] sub_sel;

    assign ext_on    = extension_enable_bit_i;                              // RL21
    assign dec_movs  = ext_on && instr_i[15:8] == `ISIE_OP_MOVS;            // RL3 RL4
    assign dec_push  = ext_on && instr_i[15:8] == `ISIE_OP_PUSH;            // RL12
    assign dec_sub   = ext_on && instr_i[15:8] == `ISIE_OP_SUB;             // RL13
    assign dec_call_via_working_register = ext_on && instr_i == `ISIE_OP_CALL_VIA_WORKING_REGISTER;                 // RL1
    assign sub_sel   = instr_i[7:6];
    assign w2_ok     = instr_i[15:12] == `ISIE_W2_PREFIX;                   // RL3 RL4
    // 12-bit sum wraps inside the data space, so every address is reachable
    assign src_addr  = 12'(indirect_pointer[2] + {5'h00, instr_i[6:0]});                 // RL2 RL5 RL6
    assign dst_addr  = mov_indexed ? 12'(indirect_pointer[2] + {5'h00, instr_i[6:0]})    // RL5
                                   : instr_i[11:0];                         // RL2 RL6

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        next_state         = state;
        next_fsr           = indirect_pointer;
        next_mov_indexed   = mov_indexed;
        next_src_indirect  = src_indirect;
        next_rd_en         = 1'b0;
        next_rd_addr       = rd_addr_o;
        next_wr_en         = 1'b0;
        next_wr_addr       = wr_addr_o;
        next_wr_data       = wr_data_o;
        next_pc_load       = 1'b0;
        next_pc_target     = pc_target_o;
        next_ret_push      = 1'b0;
        next_ret_push_data = ret_push_data_o;
        next_ret_pop       = 1'b0;
        case (state)
            ST_IDLE: begin
                if (instr_valid_i) begin
                    if (dec_movs) begin
                        // source read in first cycle
                        next_mov_indexed  = instr_i[`ISIE_MOVS_KIND_BIT];  // RL3 RL4
                        next_rd_en        = 1'b1;                          // RL10
                        next_rd_addr      = src_addr;
                        next_src_indirect = is_indirect(src_addr);         // RL8
                        next_state        = ST_MOV2;
                    end else if (dec_push) begin
                        next_wr_en   = 1'b1;                               // RL11
                        next_wr_addr = indirect_pointer[2];
                        next_wr_data = instr_i[7:0];
                        next_fsr[2]  = 12'(indirect_pointer[2] - 12'h001);              // RL11
                    end else if (dec_sub) begin
                        if (sub_sel == `ISIE_SUB_RET_SEL) begin
                            next_fsr[2]    = 12'(indirect_pointer[2] - {6'h00, instr_i[5:0]}); // RL14
                            next_pc_load   = 1'b1;                         // RL14
                            next_pc_target = return_stack_top_i;
                            next_ret_pop   = 1'b1;
                            next_state     = ST_NOP2;
                        end else begin
                            next_fsr[sub_sel] =
                                12'(indirect_pointer[sub_sel] - {6'h00, instr_i[5:0]}); // RL13
                        end
                    end else if (dec_call_via_working_register) begin
                        next_ret_push      = 1'b1;                         // RL1
                        next_ret_push_data = 21'(pc_i + `ISIE_PC_STEP);
                        next_pc_load       = 1'b1;
                        next_pc_target     = {program_counter_upper_latch_i,
                                              program_counter_high_latch_i,
                                              working_register_i};
                        next_state         = ST_NOP2;
                    end
                end
            end
            ST_MOV2: begin
                // hold the read until the second word shows up
                next_rd_en = 1'b1;
                if (instr_valid_i) begin
                    next_rd_en   = 1'b0;
                    next_state   = ST_IDLE;
                    next_wr_addr = dst_addr;
                    next_wr_data = src_indirect ? `ISIE_ZERO_DATA : rd_data_i; // RL8
                    // a malformed second word aborts without writing
                    next_wr_en   = w2_ok && !(mov_indexed && is_indirect(dst_addr)); // RL9 RL10
                end
            end
            ST_NOP2: begin
                next_state = ST_IDLE;                                      // RL14
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        next_busy = next_state != ST_IDLE;
    end

    // standard operand mapping, one address per request
    always_comb begin
        next_std_valid = std_valid_i;
        next_std_dest  = !std_dest_i;                                      // RL20
        if (std_access_i) begin
            next_std_addr = {bank_select_register_i, std_file_i};          // RL16
        end else if (ext_on && std_file_i <= `ISIE_OFFSET_MAX) begin
            next_std_addr = 12'(indirect_pointer[2] + {4'h0, std_file_i});              // RL15 RL17 RL19
        end else if (std_file_i < `ISIE_ACCESS_SPLIT) begin
            next_std_addr = {4'h0, std_file_i};                            // RL16 RL18
        end else begin
            next_std_addr = {`ISIE_ACCESS_HI_BASE, std_file_i};            // RL16 RL18
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state              <= ST_IDLE;
            indirect_pointer[0]             <= `ISIE_FSR_RESET;
            indirect_pointer[1]             <= `ISIE_FSR_RESET;
            indirect_pointer[2]             <= `ISIE_FSR_RESET;
            mov_indexed        <= 1'b0;
            src_indirect       <= 1'b0;
            rd_en_o            <= 1'b0;
            rd_addr_o          <= 12'h000;
            wr_en_o            <= 1'b0;
            wr_addr_o          <= 12'h000;
            wr_data_o          <= 8'h00;
            pc_load_o          <= 1'b0;
            pc_target_o        <= 21'h000000;
            ret_push_o         <= 1'b0;
            ret_push_data_o    <= 21'h000000;
            ret_pop_o          <= 1'b0;
            busy_o             <= 1'b0;
            std_addr_valid_o   <= 1'b0;
            std_addr_o         <= 12'h000;
            std_dest_to_work_o <= 1'b0;
        end else begin
            state              <= next_state;
            indirect_pointer                <= next_fsr;
            mov_indexed        <= next_mov_indexed;
            src_indirect       <= next_src_indirect;
            rd_en_o            <= next_rd_en;
            rd_addr_o          <= next_rd_addr;
            wr_en_o            <= next_wr_en;
            wr_addr_o          <= next_wr_addr;
            wr_data_o          <= next_wr_data;
            pc_load_o          <= next_pc_load;
            pc_target_o        <= next_pc_target;
            ret_push_o         <= next_ret_push;
            ret_push_data_o    <= next_ret_push_data;
            ret_pop_o          <= next_ret_pop;
            busy_o             <= next_busy;
            std_addr_valid_o   <= next_std_valid;
            std_addr_o         <= next_std_addr;
            std_dest_to_work_o <= next_std_dest;
        end
    end

    assign indirect_pointer0_o      = indirect_pointer[0];
    assign indirect_pointer1_o      = indirect_pointer[1];
    assign stack_pointer_register_o = indirect_pointer[2];

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_push_taken;
        state == ST_IDLE && instr_valid_i && dec_push;
    endsequence
    sequence s_movs_word1;
        state == ST_IDLE && instr_valid_i && dec_movs;
    endsequence
    sequence s_ret_taken;
        state == ST_IDLE && instr_valid_i && dec_sub && sub_sel == 2'h3;
    endsequence

    chk_push_write: assert property (s_push_taken |=> wr_en_o // RL11
        && wr_addr_o == $past(indirect_pointer[2]) && wr_data_o == $past(instr_i[7:0])
        && indirect_pointer[2] == 12'($past(indirect_pointer[2]) - 12'h001))
        else $error("push literal write or decrement wrong");
    chk_movs_read: assert property (s_movs_word1 |=> rd_en_o && state == ST_MOV2 // RL2
        && rd_addr_o == 12'($past(indirect_pointer[2]) + {5'h00, $past(instr_i[6:0])}))
        else $error("indexed move source address wrong");
    chk_src_zero: assert property (state == ST_MOV2 && instr_valid_i && src_indirect // RL8
        |=> wr_data_o == 8'h00)
        else $error("indirect source did not read zero");
    chk_dst_nop: assert property (state == ST_MOV2 && instr_valid_i && mov_indexed // RL9
        && is_indirect(dst_addr) |=> !wr_en_o)
        else $error("indirect destination was written");
    chk_ret_two: assert property (s_ret_taken |=> pc_load_o && ret_pop_o && busy_o // RL14
        ##1 !pc_load_o && !busy_o)
        else $error("subtract and return sequence wrong");
    chk_sub_flags: assert property (state == ST_IDLE && instr_valid_i && dec_sub // RL13
        && sub_sel != 2'h3 |=> !wr_en_o && !pc_load_o && state == ST_IDLE)
        else $error("pointer subtract did more than subtract");
    chk_ext_off: assert property (!extension_enable_bit_i && state == ST_IDLE // RL21
        |=> !wr_en_o && !pc_load_o && !rd_en_o)
        else $error("extended operation ran while disabled");
    chk_std_offset: assert property (std_valid_i && !std_access_i // RL17
        && extension_enable_bit_i && std_file_i <= 8'h5F
        |=> std_addr_o == 12'($past(indirect_pointer[2]) + {4'h0, $past(std_file_i)}))
        else $error("indexed offset address wrong");
    chk_call_via_working_register_push: assert property (state == ST_IDLE && instr_valid_i && dec_call_via_working_register // RL1
        |=> ret_push_o && ret_push_data_o == 21'($past(pc_i) + 21'h000002)
        && pc_target_o[7:0] == $past(working_register_i))
        else $error("call via working register wrong");
endmodule // isie_core

// ===== bench/isie_mem_model.sv
`timescale 1ns/1ps

// ************************************************************
// data memory on the far side of the block
// ************************************************************
module isie_mem_model (
    // clock
    input  wire logic                 clk_i,
    // read port
    input  wire logic                 rd_en_i,
    input  wire isie_pkg::isie_addr_t rd_addr_i,
    output logic [7:0]                rd_data_o,
    // write port
    input  wire logic                 wr_en_i,
    input  wire isie_pkg::isie_addr_t wr_addr_i,
    input  wire logic [7:0]           wr_data_i
);
    import isie_pkg::*;

    logic [7:0] mem [0:4095];
    logic [7:0] last;

    initial begin
        for (int a = 0; a < 4096; a++) begin
            mem[a] = a[7:0] ^ 8'hA5;
        end
        last = 8'h00;
    end

    // an unselected read shows the inverse of the last value so stale data never matches
    always_comb begin
        rd_data_o = rd_en_i ? mem[rd_addr_i] : ~last;
    end

    always @(posedge clk_i) begin
        if (rd_en_i) begin
            last <= mem[rd_addr_i];
        end
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end
endmodule // isie_mem_model

// ===== bench/test_isie_core.sv
`timescale 1ns/1ps
`include "isie_consts.svh"

module test_isie_core;
    import isie_pkg::*;

    logic       clk_i, resetn_i, extension_enable_bit_i, instr_valid_i, std_valid_i;
    logic       std_access_i, std_dest_i, rd_en_o, wr_en_o, pc_load_o, ret_push_o;
    logic       ret_pop_o, busy_o, std_addr_valid_o, std_dest_to_work_o;
    logic [15:0] instr_i;
    logic [7:0] working_register_i, program_counter_high_latch_i, rd_data_i, std_file_i;
    logic [7:0] wr_data_o;
    logic [4:0] program_counter_upper_latch_i;
    logic [3:0] bank_select_register_i;
    isie_pc_t   pc_i, return_stack_top_i, pc_target_o, ret_push_data_o;
    isie_addr_t rd_addr_o, wr_addr_o, indirect_pointer0_o, indirect_pointer1_o;
    isie_addr_t stack_pointer_register_o, std_addr_o;
    isie_addr_t ptr [0:2];
    logic [7:0] shm [0:4095];
    int         mismatches, tests_run;

    isie_core i_isie_core (.clk_i(clk_i), .resetn_i(resetn_i),
        .extension_enable_bit_i(extension_enable_bit_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .working_register_i(working_register_i), .pc_i(pc_i),
        .program_counter_high_latch_i(program_counter_high_latch_i),
        .program_counter_upper_latch_i(program_counter_upper_latch_i),
        .return_stack_top_i(return_stack_top_i), .bank_select_register_i(bank_select_register_i),
        .std_valid_i(std_valid_i), .std_file_i(std_file_i), .std_access_i(std_access_i),
        .std_dest_i(std_dest_i), .rd_data_i(rd_data_i), .rd_en_o(rd_en_o), .rd_addr_o(rd_addr_o),
        .wr_en_o(wr_en_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
        .indirect_pointer0_o(indirect_pointer0_o), .indirect_pointer1_o(indirect_pointer1_o),
        .stack_pointer_register_o(stack_pointer_register_o), .pc_load_o(pc_load_o),
        .pc_target_o(pc_target_o), .ret_push_o(ret_push_o), .ret_push_data_o(ret_push_data_o),
        .ret_pop_o(ret_pop_o), .busy_o(busy_o), .std_addr_valid_o(std_addr_valid_o),
        .std_addr_o(std_addr_o), .std_dest_to_work_o(std_dest_to_work_o));

    isie_mem_model i_isie_mem_model (.clk_i(clk_i), .rd_en_i(rd_en_o), .rd_addr_i(rd_addr_o),
        .rd_data_o(rd_data_i), .wr_en_i(wr_en_o), .wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o));

    // ************************************************************
    // checking helpers
    // ************************************************************
    task automatic note(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("ERROR at %0t: %s", $time, what);
        end
    endtask
    task automatic cmp_flag(input logic g, input logic e, input string w); note(g === e, w); endtask
    task automatic cmp_addr(input isie_addr_t g, input isie_addr_t e, input string w);
        note(g === e, w);
    endtask
    task automatic cmp_data(input logic [7:0] g, input logic [7:0] e, input string w);
        note(g === e, w);
    endtask
    task automatic cmp_pc(input isie_pc_t g, input isie_pc_t e, input string w); note(g === e, w); endtask

    function automatic logic in_window(input isie_addr_t a);
        return (a - `ISIE_IND0_BASE < `ISIE_IND_SPAN) || (a - `ISIE_IND1_BASE < `ISIE_IND_SPAN)
            || (a - `ISIE_IND2_BASE < `ISIE_IND_SPAN);
    endfunction

    // ************************************************************
    // stimulus tasks
    // ************************************************************
    // one call per falling edge, so no input is written twice in a time step
    task automatic drive(input logic v, input logic [15:0] w);
        instr_valid_i = v;
        instr_i = w;
        working_register_i = $urandom;
        pc_i = $urandom;
        program_counter_high_latch_i = $urandom;
        program_counter_upper_latch_i = $urandom;
        return_stack_top_i = $urandom;
        bank_select_register_i = $urandom;
        @(negedge clk_i);
    endtask

    task automatic std_op(input logic [7:0] f, input logic a, input logic d);
        isie_addr_t e;
        std_valid_i = 1'b1;
        std_file_i = f;
        std_access_i = a;
        std_dest_i = d;
        drive(1'b0, 16'h0000);
        if (a) e = {bank_select_register_i, f};
        else if (extension_enable_bit_i && f <= `ISIE_OFFSET_MAX) e = ptr[2] + {4'h0, f};
        else if (f < `ISIE_ACCESS_SPLIT) e = {4'h0, f};
        else e = {`ISIE_ACCESS_HI_BASE, f};
        cmp_flag(std_addr_valid_o, 1'b1, "operand valid");
        cmp_addr(std_addr_o, e, "operand address");
        cmp_flag(std_dest_to_work_o, ~d, "destination select");
    endtask

    task automatic sub_ptr(input logic [1:0] f, input logic [5:0] k);
        drive(1'b1, {`ISIE_OP_SUB, f, k});
        ptr[f] = ptr[f] - {6'h00, k};
        cmp_addr(indirect_pointer0_o, ptr[0], "pointer 0");
        cmp_addr(indirect_pointer1_o, ptr[1], "pointer 1");
        cmp_addr(stack_pointer_register_o, ptr[2], "stack pointer");
        cmp_flag(busy_o, 1'b0, "subtract one cycle");
    endtask

    task automatic set_sp(input isie_addr_t t);
        isie_addr_t d;
        d = ptr[2] - t;
        while (d != 12'h000) begin
            sub_ptr(2'h2, (d > 12'h03F) ? 6'h3F : d[5:0]);
            d = ptr[2] - t;
        end
    endtask

    task automatic move(input logic idx, input logic [6:0] zs, input logic [11:0] fd);
        isie_addr_t src, dst;
        logic [7:0] v;
        src = ptr[2] + {5'h00, zs};
        dst = idx ? ptr[2] + {5'h00, fd[6:0]} : fd;
        v = in_window(src) ? `ISIE_ZERO_DATA : shm[src];
        drive(1'b1, {`ISIE_OP_MOVS, idx, zs});
        cmp_flag(rd_en_o, 1'b1, "move read");
        cmp_addr(rd_addr_o, src, "move source");
        cmp_flag(busy_o, 1'b1, "move second cycle");
        drive(1'b1, {`ISIE_W2_PREFIX, fd});
        if (idx && in_window(dst)) begin
            cmp_flag(wr_en_o, 1'b0, "indirect target");
        end else begin
            cmp_flag(wr_en_o, 1'b1, "move write");
            cmp_addr(wr_addr_o, dst, "move target");
            cmp_data(wr_data_o, v, "move data");
            shm[dst] = v;
        end
        cmp_flag(busy_o, 1'b0, "move done");
    endtask

    task automatic complete_run();
        $display("TB: %0d comparisons, %0d mismatches", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ************************************************************
    // clock, watchdog, main sequence
    // ************************************************************
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    initial begin
        #400000;
        mismatches++;
        complete_run();
    end

    initial begin
        logic [7:0] k;
        mismatches = 0;
        tests_run = 0;
        resetn_i = 1'b0;
        extension_enable_bit_i = 1'b0;
        std_valid_i = 1'b0;
        std_file_i = 8'h00;
        std_access_i = 1'b0;
        std_dest_i = 1'b0;
        void'($urandom(66291));
        for (int a = 0; a < 4096; a++) shm[a] = a[7:0] ^ 8'hA5;
        for (int i = 0; i < 3; i++) ptr[i] = `ISIE_FSR_RESET;
        drive(1'b0, 16'h0000);
        repeat (7) drive(1'b0, 16'h0000);
        resetn_i = 1'b1;
        cmp_addr(stack_pointer_register_o, 12'h000, "reset pointer");
        cmp_flag(wr_en_o, 1'b0, "reset write");
        // extension off: extended words are ignored, access bit picks the bank
        drive(1'b1, {`ISIE_OP_PUSH, 8'h5A});
        cmp_flag(wr_en_o, 1'b0, "push while off");
        std_op(8'h10, 1'b0, 1'b1);
        std_op($urandom, 1'b1, 1'b0);
        $display("test extension off done");
        extension_enable_bit_i = 1'b1;
        std_op(8'h5F, 1'b0, 1'b0);
        for (int i = 0; i < 9; i++) sub_ptr(i % 3, $urandom);
        std_op(8'h5F, 1'b0, 1'b1);
        std_op(8'h60, 1'b0, 1'b0);
        std_op(8'hA0, 1'b0, 1'b1);
        std_op(8'h00, 1'b1, 1'b1);
        std_valid_i = 1'b0;
        drive(1'b0, 16'h0000);
        cmp_flag(std_addr_valid_o, 1'b0, "operand idle");
        $display("test operand addressing done");
        for (int i = 0; i < 6; i++) begin
            k = $urandom;
            drive(1'b1, {`ISIE_OP_PUSH, k});
            cmp_flag(wr_en_o, 1'b1, "push write");
            cmp_addr(wr_addr_o, ptr[2], "push address");
            cmp_data(wr_data_o, k, "push data");
            shm[ptr[2]] = k;
            ptr[2] = ptr[2] - 12'h001;
            cmp_addr(stack_pointer_register_o, ptr[2], "push pointer");
        end
        $display("test push done");
        // targets stay below the counter and return stack bytes
        for (int i = 0; i < 8; i++) move(i[0], $urandom, $urandom_range(12'hEFF, 12'h000));
        move(1'b0, 7'h7F, 12'h000);
        set_sp(12'hFDB);
        move(1'b0, 7'h00, 12'h123);
        move(1'b1, 7'h01, 12'hF90);
        move(1'b1, 7'h04, 12'h005);
        // a second word without the fixed prefix must leave memory alone
        drive(1'b1, {`ISIE_OP_MOVS, 8'h05});
        drive(1'b1, 16'h1234);
        cmp_flag(wr_en_o, 1'b0, "malformed second word");
        cmp_flag(busy_o, 1'b0, "malformed word ends move");
        $display("test moves done");
        k = $urandom_range(63, 0);
        drive(1'b1, {`ISIE_OP_SUB, `ISIE_SUB_RET_SEL, k[5:0]});
        ptr[2] = ptr[2] - {6'h00, k[5:0]};
        cmp_addr(stack_pointer_register_o, ptr[2], "return pointer");
        cmp_flag(ret_pop_o, 1'b1, "return pop");
        cmp_flag(pc_load_o, 1'b1, "return load");
        cmp_pc(pc_target_o, return_stack_top_i, "return target");
        cmp_flag(busy_o, 1'b1, "return second cycle");
        drive(1'b1, {`ISIE_OP_PUSH, 8'h77});
        cmp_flag(wr_en_o, 1'b0, "word in no-op cycle");
        drive(1'b1, `ISIE_OP_CALL_VIA_WORKING_REGISTER);
        cmp_flag(ret_push_o, 1'b1, "call push");
        cmp_pc(ret_push_data_o, isie_pc_t'(pc_i + `ISIE_PC_STEP), "call return address");
        cmp_pc(pc_target_o, {program_counter_upper_latch_i, program_counter_high_latch_i,
            working_register_i}, "call target");
        drive(1'b0, 16'h0000);
        cmp_flag(pc_load_o, 1'b0, "call done");
        $display("test flow done");
        complete_run();
    end
endmodule // test_isie_core
